// >>> src/gsarc_pkg.sv
// Function
// - 'z' query returns unfiltered gas, five digits
// - '.' query returns scaling multiplier, five digits
// - Multiplier 1, 10 or 100 by range
// - 'T' query returns ten times Celsius plus 1000
// - 'H' query returns ten times relative humidity
// - Absent sensors answer 01000 and 00000
// - Field is identifier, space, five digits
// - Mask weights select report fields
// - Mask is sum of field weights
// - 'M' sets mask, echoed zero padded
// - Mask resets to 6
// - Lines end with CR LF
// - 'Q' query emits selected fields whose FIELD_DEF bit is set
// - Streaming mode emits same report lines
package gsarc_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned VAL_W  = 16;
  localparam int unsigned NUM_W  = 17;
  localparam int unsigned NFIELD = 13;
  localparam int unsigned CTRL_W = 5;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_TRIG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_LCMD = 8'h0C;
  localparam logic [1:0] REG_VAL_PAGE = 2'h1;

  // Field positions
  localparam int unsigned CTRL_STREAM = 0;
  localparam int unsigned CTRL_RANGE  = 1;
  localparam int unsigned CTRL_TEMP   = 3;
  localparam int unsigned CTRL_HUM    = 4;
  localparam int unsigned STAT_BUSY   = 17;
  localparam int unsigned STAT_PEND   = 18;

  // Reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [NUM_W-1:0]  MASK_RST = 17'h00006;

  // Report fields
  localparam logic [12:0] FIELD_DEF = 13'h1DFE;
  localparam logic [3:0]  FLD_NONE  = 4'h0;
  localparam logic [3:0]  FLD_UNF   = 4'h1;
  localparam logic [3:0]  FLD_TEMP  = 4'h6;
  localparam logic [3:0]  FLD_GAP   = 4'h9;
  localparam logic [3:0]  FLD_HUM   = 4'hC;
  localparam logic [3:0]  FLD_TOP   = 4'hC;

  // Characters
  localparam logic [7:0] CH_UNF   = 8'h7A;
  localparam logic [7:0] CH_SCALE = 8'h2E;
  localparam logic [7:0] CH_TEMP  = 8'h54;
  localparam logic [7:0] CH_HUM   = 8'h48;
  localparam logic [7:0] CH_MASK  = 8'h4D;
  localparam logic [7:0] CH_REP   = 8'h51;
  localparam logic [7:0] CH_SP    = 8'h20;
  localparam logic [7:0] CH_CR    = 8'h0D;
  localparam logic [7:0] CH_LF    = 8'h0A;
  localparam logic [7:0] CH_D0    = 8'h30;
  localparam logic [7:0] CH_D9    = 8'h39;
  localparam logic [7:0] CH_NUL   = 8'h00;

  // Values
  localparam logic [NUM_W-1:0] TEMP_ABSENT = 17'h003E8;
  localparam logic [NUM_W-1:0] HUM_ABSENT  = 17'h00000;
  localparam logic [NUM_W-1:0] SCALE_1     = 17'h00001;
  localparam logic [NUM_W-1:0] SCALE_10    = 17'h0000A;
  localparam logic [NUM_W-1:0] SCALE_100   = 17'h00064;
  localparam logic [1:0]       RANGE_60    = 2'h1;
  localparam logic [1:0]       RANGE_100   = 2'h2;
  localparam logic [2:0]       ARG_DIGITS  = 3'h5;
  localparam logic [2:0]       DIG_TOP     = 3'h4;

  typedef enum logic [2:0] {
    TX_IDLE, TX_SCAN, TX_SEP, TX_ID, TX_SP, TX_DIG, TX_CR, TX_LF
  } gsarc_tx_e;

  function automatic logic [7:0] field_char(input logic [3:0] i);
    case (i)
      4'hC:    return 8'h48;
      4'hB:    return 8'h64;
      4'hA:    return 8'h44;
      4'h8:    return 8'h68;
      4'h7:    return 8'h56;
      4'h6:    return 8'h54;
      4'h5:    return 8'h4F;
      4'h4:    return 8'h6F;
      4'h3:    return 8'h76;
      4'h2:    return 8'h5A;
      4'h1:    return 8'h7A;
      default: return CH_NUL;
    endcase
  endfunction : field_char

  function automatic logic [7:0] dec_digit(input logic [NUM_W-1:0] v, input logic [2:0] k);
    logic [NUM_W-1:0] p;
    logic [NUM_W-1:0] r;
    case (k)
      3'h4:    p = 17'h02710;
      3'h3:    p = 17'h003E8;
      3'h2:    p = 17'h00064;
      3'h1:    p = 17'h0000A;
      default: p = 17'h00001;
    endcase
    r = (v / p) % 17'h0000A;
    return CH_D0 + {4'h0, r[3:0]};
  endfunction : dec_digit
endpackage : gsarc_pkg

// >>> src/gsarc_fifo.sv
`timescale 1ns/10ps
module gsarc_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } gsarc_fifo_s;

  gsarc_fifo_s q;
  gsarc_fifo_s d;
  logic        push;
  logic        pop;

  assign in_ready  = (q.cnt != FULL);
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp        = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    if (push && !pop) begin
      d.cnt = q.cnt + 1'b1;
    end else if (pop && !push) begin
      d.cnt = q.cnt - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : gsarc_fifo

// >>> src/gsarc_core.sv
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module gsarc_core (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // AHB-Lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic [31:0]                       hrdata,
  // Received command bytes
  input  wire logic                         rx_valid,
  input  wire logic [gsarc_pkg::BYTE_W-1:0] rx_data,
  output logic                              rx_ready,
  // Reply bytes
  output logic                              tx_valid,
  output logic [gsarc_pkg::BYTE_W-1:0]      tx_data,
  input  wire logic                         tx_ready
);
  import gsarc_pkg::*;

  typedef struct packed {
    logic [NUM_W-1:0]               mask;
    logic [CTRL_W-1:0]              ctrl;
    logic [NFIELD-1:0][VAL_W-1:0]   vals;
    logic [7:0]                     cmd;
    logic [NUM_W-1:0]               arg;
    logic [2:0]                     ndig;
    logic                           cr;
    logic                           first_ch;
    gsarc_tx_e                      tx;
    logic [7:0]                     id;
    logic [NUM_W-1:0]               val;
    logic [2:0]                     dig;
    logic [3:0]                     fidx;
    logic                           rep;
    logic                           first_fld;
    logic                           pend;
    logic [7:0]                     lcmd;
    logic [7:0]                     lastb;
    logic                           wr;
    logic [7:0]                     waddr;
    logic [31:0]                    rdata;
  } gsarc_core_s;

  gsarc_core_s      q;
  gsarc_core_s      d;
  logic             out_valid;
  logic [7:0]       out_byte;
  logic             buf_ready;
  logic             emit;
  logic             rx_take;
  logic             exec;
  logic             sel;
  logic             in_map;
  logic [31:0]      rd_word;
  logic [1:0]       range;
  logic             temp_fit;
  logic             hum_fit;
  logic [NUM_W-1:0] scale;
  logic [VAL_W-1:0] unf_raw;
  logic [VAL_W-1:0] hum_raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Field values and scaling

  assign range    = q.ctrl[CTRL_RANGE +: 2];
  assign temp_fit = q.ctrl[CTRL_TEMP];
  assign hum_fit  = q.ctrl[CTRL_HUM];
  assign unf_raw  = q.vals[FLD_UNF];
  assign hum_raw  = q.vals[FLD_HUM];

  always_comb begin
    case (range)
      RANGE_60:  scale = SCALE_10;
      RANGE_100: scale = SCALE_100;
      default:   scale = SCALE_1;
    endcase
  end

  function automatic logic [NUM_W-1:0] field_val(input logic [3:0] i,
                                                 input gsarc_core_s s);
    if (i == FLD_TEMP && !s.ctrl[CTRL_TEMP]) begin
      return TEMP_ABSENT;
    end else if (i == FLD_HUM && !s.ctrl[CTRL_HUM]) begin
      return HUM_ABSENT;
    end
    return {1'b0, s.vals[i]};
  endfunction : field_val

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = q.rdata;
  assign in_map    = (haddr[31:8] == 24'h000000);
  assign sel       = hsel && hready && htrans[1] && in_map;

  always_comb begin
    rd_word = 32'h00000000;
    if (haddr[7:6] == REG_VAL_PAGE) begin
      if (haddr[5:2] < 4'(NFIELD)) begin
        rd_word = {16'h0000, q.vals[haddr[5:2]]};
      end
    end else begin
      case (haddr[7:0])
        REG_CTRL: rd_word = {27'h0000000, q.ctrl};
        REG_STAT: rd_word = {13'h0000, q.pend, q.tx != TX_IDLE, q.mask};
        REG_LCMD: rd_word = {24'h000000, q.lcmd};
        default:  rd_word = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply byte selection

  always_comb begin
    out_valid = 1'b1;
    out_byte  = CH_SP;
    case (q.tx)
      TX_SEP:  out_byte = CH_SP;
      TX_SP:   out_byte = CH_SP;
      TX_ID:   out_byte = q.id;
      TX_DIG:  out_byte = dec_digit(q.val, q.dig);
      TX_CR:   out_byte = CH_CR;
      TX_LF:   out_byte = CH_LF;
      default: out_valid = 1'b0;
    endcase
  end

  assign emit     = out_valid && buf_ready;
  assign rx_ready = (q.tx == TX_IDLE);
  assign rx_take  = rx_valid && rx_ready;
  assign exec     = rx_take && (rx_data == CH_LF) && q.cr && !q.first_ch;

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [NUM_W-1:0] m;
    m = q.mask;
    d = q;
    if (emit) begin
      d.lastb = out_byte;
    end
    // Reply sequencer
    case (q.tx)
      TX_IDLE: begin
        if (q.pend && !rx_take) begin
          d.tx        = TX_SCAN;
          d.rep       = 1'b1;
          d.fidx      = FLD_TOP;
          d.first_fld = 1'b1;
          d.pend      = 1'b0;
        end
      end
      TX_SCAN: begin
        if (q.fidx == FLD_NONE) begin
          d.tx = TX_CR;
        end else begin
          if (q.mask[q.fidx] && FIELD_DEF[q.fidx]) begin
            d.id        = field_char(q.fidx);
            d.val       = field_val(q.fidx, q);
            d.tx        = q.first_fld ? TX_ID : TX_SEP;
            d.first_fld = 1'b0;
          end
          d.fidx = q.fidx - 4'h1;
        end
      end
      TX_SEP: begin
        if (emit) begin
          d.tx = TX_ID;
        end
      end
      TX_ID: begin
        if (emit) begin
          d.tx = TX_SP;
        end
      end
      TX_SP: begin
        if (emit) begin
          d.tx  = TX_DIG;
          d.dig = DIG_TOP;
        end
      end
      TX_DIG: begin
        if (emit) begin
          if (q.dig == 3'h0) begin
            d.tx = q.rep ? TX_SCAN : TX_CR;
          end else begin
            d.dig = q.dig - 3'h1;
          end
        end
      end
      TX_CR: begin
        if (emit) begin
          d.tx = TX_LF;
        end
      end
      TX_LF: begin
        if (emit) begin
          d.tx = TX_IDLE;
        end
      end
      default: d.tx = TX_IDLE;
    endcase
    // Command line parser
    if (rx_take) begin
      if (rx_data == CH_LF) begin
        d.first_ch = 1'b1;
        d.cr       = 1'b0;
      end else if (rx_data == CH_CR) begin
        d.cr = 1'b1;
        if (q.first_ch) begin
          d.cmd      = CH_NUL;
          d.first_ch = 1'b0;
        end
      end else begin
        d.cr = 1'b0;
        if (q.first_ch) begin
          d.cmd      = rx_data;
          d.first_ch = 1'b0;
          d.arg      = '0;
          d.ndig     = 3'h0;
        end else if (rx_data >= CH_D0 && rx_data <= CH_D9 && q.ndig < ARG_DIGITS) begin
          d.arg  = NUM_W'(q.arg * 17'h0000A + {13'h0000, rx_data[3:0]});
          d.ndig = q.ndig + 3'h1;
        end
      end
    end
    // Command execution
    if (exec) begin
      d.lcmd = q.cmd;
      d.rep  = 1'b0;
      d.tx   = TX_ID;
      d.id   = q.cmd;
      case (q.cmd)
        CH_UNF:   d.val = {1'b0, q.vals[FLD_UNF]};
        CH_SCALE: d.val = scale;
        CH_TEMP:  d.val = field_val(FLD_TEMP, q);
        CH_HUM:   d.val = field_val(FLD_HUM, q);
        CH_MASK: begin
          if (q.ndig != 3'h0) begin
            m = q.arg;
          end
          d.mask = m;
          d.val  = m;
        end
        CH_REP: begin
          d.tx        = TX_SCAN;
          d.rep       = 1'b1;
          d.fidx      = FLD_TOP;
          d.first_fld = 1'b1;
        end
        default: d.tx = TX_IDLE;
      endcase
    end
    // Bus data phase
    if (q.wr) begin
      if (q.waddr[7:6] == REG_VAL_PAGE) begin
        if (q.waddr[5:2] < 4'(NFIELD)) begin
          d.vals[q.waddr[5:2]] = hwdata[VAL_W-1:0];
        end
      end else if (q.waddr == REG_CTRL) begin
        d.ctrl = hwdata[CTRL_W-1:0];
      end else if (q.waddr == REG_TRIG && q.ctrl[CTRL_STREAM]) begin
        d.pend = 1'b1;
      end
    end
    // Bus address phase
    d.wr = sel && hwrite;
    if (sel) begin
      d.waddr = haddr[7:0];
      if (!hwrite) begin
        d.rdata = rd_word;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q          <= '0;
      q.mask     <= MASK_RST;
      q.ctrl     <= CTRL_RST;
      q.first_ch <= 1'b1;
      q.tx       <= TX_IDLE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply buffer

  gsarc_fifo #(
    .W     (BYTE_W),
    .DEPTH (2)
  ) u_txbuf (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_valid  (out_valid),
    .in_data   (out_byte),
    .in_ready  (buf_ready),
    .out_valid (tx_valid),
    .out_data  (tx_data),
    .out_ready (tx_ready)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_unf_reply;
    exec && q.cmd == CH_UNF |=> q.tx == TX_ID && q.id == CH_UNF
      && q.val == {1'b0, $past(unf_raw)};
  endproperty
  a_unf_reply: assert property (p_unf_reply) else $error("unfiltered reply wrong");

  property p_scale;
    exec && q.cmd == CH_SCALE |=> q.id == CH_SCALE && q.val ==
      (($past(range) == RANGE_100) ? SCALE_100 : ($past(range) == RANGE_60) ? SCALE_10 : SCALE_1);
  endproperty
  a_scale: assert property (p_scale) else $error("scale reply wrong");

  property p_temp_abs;
    exec && q.cmd == CH_TEMP && !temp_fit |=> q.tx == TX_ID && q.val == TEMP_ABSENT;
  endproperty
  a_temp_abs: assert property (p_temp_abs) else $error("absent temperature wrong");

  property p_hum;
    exec && q.cmd == CH_HUM && hum_fit |=> q.val == {1'b0, $past(hum_raw)};
  endproperty
  a_hum: assert property (p_hum) else $error("humidity reply wrong");

  property p_digits;
    q.tx == TX_SP && emit |=> q.tx == TX_DIG && q.dig == DIG_TOP;
  endproperty
  a_digits: assert property (p_digits) else $error("digit run not five");

  property p_mask_set;
    !$stable(q.mask) |-> $past(exec) && $past(q.cmd) == CH_MASK;
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask changed without command");

  property p_crlf;
    emit && out_byte == CH_LF |-> q.lastb == CH_CR;
  endproperty
  a_crlf: assert property (p_crlf) else $error("line feed without carriage return");

  property p_report;
    exec && q.cmd == CH_REP |=> q.tx == TX_SCAN && q.fidx == FLD_TOP && q.rep;
  endproperty
  a_report: assert property (p_report) else $error("report not started");

  property p_stream;
    q.tx == TX_IDLE && q.pend && !rx_valid |=> q.tx == TX_SCAN && q.rep;
  endproperty
  a_stream: assert property (p_stream) else $error("stream report not started");

  property p_gap;
    q.tx == TX_SCAN && q.fidx == FLD_GAP |=> q.tx == TX_SCAN && q.fidx == 4'h8;
  endproperty
  a_gap: assert property (p_gap) else $error("undefined field emitted");

  property p_end;
    q.tx == TX_SCAN && q.fidx == FLD_NONE |=> q.tx == TX_CR;
  endproperty
  a_end: assert property (p_end) else $error("report line not closed");

  c_report: cover property (exec && q.cmd == CH_REP);
  c_mask:   cover property (exec && q.cmd == CH_MASK && q.ndig != 3'h0);
  c_stall:  cover property (out_valid && !buf_ready);
  c_stream: cover property (q.tx == TX_IDLE && q.pend);
endmodule : gsarc_core

// >>> dv/gsarc_host.sv
`timescale 1ns/10ps
module gsarc_host (
  // Clock and reset
  input  wire logic                         hclk,
  input  wire logic                         hresetn,
  // Command bytes
  output logic                              rx_valid,
  output logic [gsarc_pkg::BYTE_W-1:0]      rx_data,
  input  wire logic                         rx_ready,
  // Reply bytes
  input  wire logic                         tx_valid,
  input  wire logic [gsarc_pkg::BYTE_W-1:0] tx_data,
  output logic                              tx_ready,
  // Stall control
  input  wire logic                         slow
);
  import gsarc_pkg::*;
  logic [BYTE_W-1:0] got [$];

  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////
  // Receiver stalls every other cycle in slow mode
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_ready <= 1'b1;
    else tx_ready <= slow ? ~tx_ready : 1'b1;
  end

  always @(posedge hclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got.push_back(tx_data);
  end

  ////////////////////////////////////////////////////////////////
  // One command line, closed by CR LF
  task automatic send(input string body);
    string s;
    s = {body, "\r\n"};
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      do @(posedge hclk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask : send
endmodule : gsarc_host

// >>> dv/tb.sv
`timescale 1ns/10ps
module tb;
  import gsarc_pkg::*;
  logic              hclk;
  logic              hresetn;
  logic              hsel;
  logic              hwrite;
  logic              hready;
  logic              hresp;
  logic              slow;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic              rx_valid;
  logic              rx_ready;
  logic              tx_valid;
  logic              tx_ready;
  logic [BYTE_W-1:0] rx_data;
  logic [BYTE_W-1:0] tx_data;
  int                mismatches = 0;
  int                checks = 0;
  int                scale [4] = '{1, 10, 100, 1};

  gsarc_core uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready)
  );

  gsarc_host host (
    .hclk(hclk), .hresetn(hresetn), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .slow(slow)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////
  // Bus and comparison tasks
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    checks++;
    if (hresp !== 1'b0) begin
      mismatches++;
      $display("mismatch hresp expected 0 seen %b", hresp);
    end
  endtask : ahb

  task automatic vw(input int i, input int v);
    ahb(1'b1, 32'h40 + 32'(4 * i), 32'(v));
  endtask : vw

  task automatic chk_word(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    checks++;
    if (rd !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, rd);
    end
  endtask : chk_word

  task automatic expect_line(input string what, input string exp);
    int n;
    n = 0;
    while (host.got.size() < exp.len() && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    repeat (6) @(posedge hclk);
    checks++;
    if (host.got.size() != exp.len()) begin
      mismatches++;
      $display("mismatch %s length expected %0d seen %0d", what, exp.len(), host.got.size());
    end
    for (int i = 0; i < exp.len() && i < host.got.size(); i++) begin
      checks++;
      if (host.got[i] !== exp[i]) begin
        mismatches++;
        $display("mismatch %s byte %0d expected %h seen %h", what, i, exp[i], host.got[i]);
      end
    end
    $display("test %s done", what);
  endtask : expect_line

  task automatic cmd(input string body, input string exp);
    host.got.delete();
    host.send(body);
    expect_line(body, exp);
  endtask : cmd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b1;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hsize   = 3'h2;
    hwdata  = 32'h0;
    slow    = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_word("ctrl", {24'h0, REG_CTRL}, 32'h0);
    chk_word("status", {24'h0, REG_STAT}, 32'h6);
    // Unmapped reads leave the previous read data standing
    chk_word("unmapped", 32'h100, {15'h0000, MASK_RST});
    cmd("M", "M 00006\r\n");
    // Values already divided by the multiplier
    vw(1, 521);
    for (int i = 2; i < 12; i++) vw(i, i * 111);
    vw(2, 10);
    chk_word("value", 32'h44, 32'h00000209);
    chk_word("value", 32'h48, 32'h0000000A);
    cmd("z", "z 00521\r\n");
    for (int r = 0; r < 4; r++) begin
      ahb(1'b1, {24'h0, REG_CTRL}, 32'(r << 1));
      cmd(".", $sformatf(". %05d\r\n", scale[r]));
    end
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h0);
    cmd("T", "T 01000\r\n");
    cmd("H", "H 00000\r\n");
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h18);
    vw(6, 1224);
    vw(12, 551);
    cmd("T", "T 01224\r\n");
    cmd("H", "H 00551\r\n");
    // Host masks select at most five fields
    cmd("M 4164", "M 04164\r\n");
    slow <= 1'b1;
    cmd("Q", "H 00551 T 01224 Z 00010\r\n");
    slow <= 1'b0;
    cmd("M 3488", "M 03488\r\n");
    cmd("Q", "d 01221 D 01110 h 00888 V 00777 O 00555\r\n");
    cmd("M 24", "M 00024\r\n");
    cmd("Q", "o 00444 v 00333\r\n");
    cmd("M 4609", "M 04609\r\n");
    cmd("Q", "H 00551\r\n");
    cmd("M 6", "M 00006\r\n");
    cmd("Y", "");
    chk_word("lastcmd", {24'h0, REG_LCMD}, 32'h00000059);
    ahb(1'b1, {24'h0, REG_CTRL}, 32'h19);
    host.got.delete();
    ahb(1'b1, {24'h0, REG_TRIG}, 32'h0);
    expect_line("stream", "Z 00010 z 00521\r\n");
    tally_and_finish();
  end
endmodule : tb
